// ===== logic/route_pkg.sv
package route_pkg;

  localparam int NODE_W = 16;
  localparam int DIR_W  = 4;
  localparam int DIM_W  = 4;

  // Control token values of the configuration message protocol.
  localparam logic [7:0] TOK_WRITE = 8'hc0;
  localparam logic [7:0] TOK_END   = 8'h01;
  localparam logic [7:0] TOK_ACK   = 8'h03;
  localparam logic [7:0] TOK_NACK  = 8'h04;

  // Register numbers carried in the 16-bit field of a write message.
  localparam logic [15:0] REG_DIR_LOW  = 16'h000c;
  localparam logic [15:0] REG_DIR_HIGH = 16'h000d;

  localparam logic [31:0] DIR_LOW_RST  = 32'h00000000;
  localparam logic [31:0] DIR_HIGH_RST = 32'h00000000;

  // Bytes between the opening and closing tokens: 3 endpoint, 2 register, 4 data.
  localparam logic [3:0] HDR_BYTES = 4'h9;
  localparam logic [3:0] CNT_ONE   = 4'h1;

  typedef struct packed {
    logic       ctrl;
    logic [7:0] data;
  } token_t;

  typedef struct packed {
    logic              valid;
    logic [NODE_W-1:0] dest;
  } route_req_t;

  typedef struct packed {
    logic             valid;
    logic             local_hit;
    logic [DIR_W-1:0] dir;
  } route_rsp_t;

  typedef struct packed {
    logic [23:0] endpoint;
    logic [15:0] regnum;
    logic [31:0] wdata;
  } cfg_msg_t;

  typedef enum logic [2:0] {
    CFG_IDLE,
    CFG_HDR,
    CFG_CLOSE,
    CFG_RSP1,
    CFG_RSP2
  } cfg_state_t;

endpackage

// ===== logic/dir_select.sv
`timescale 1ns/100ps
module dir_select
  import route_pkg::*;
(
  input  wire logic [NODE_W-1:0] mismatch, // Destination XOR local identifier.
  output logic      [DIM_W-1:0]  dim,      // Highest set bit position.
  output logic                   any       // Some bit differs.
);

  // Scan upward so the last hit, the most significant one, wins.
  always_comb
  begin
    dim = '0;
    any = 1'b0;
    for (int i = 0; i < NODE_W; i++)
    begin
      if (mismatch[i])
      begin
        dim = DIM_W'(i);
        any = 1'b1;
      end
    end
  end

endmodule

// ===== logic/packet_direction_lookup.sv
`timescale 1ns/100ps
// Function
// - Route by the highest bit where destination and local identifier differ.
// - Low direction register serves dimensions zero to seven.
// - High direction register serves dimensions eight to fifteen.
// - Dimension d uses the 4-bit field starting at bit four times d.
// - Low direction register resets to zero, so all start toward direction zero.
// - Write message is token 192, endpoint, register, data, end; reply 3/1 or 4/1.
module packet_direction_lookup
  import route_pkg::*;
(
  input  wire logic              clk,            // Switch clock, 20 MHz.
  input  wire logic              rst_n,          // Asynchronous reset, active low.
  input  wire logic [NODE_W-1:0] local_id,       // Identifier of this node.
  input  wire route_req_t        req,            // Packet header to route.
  output route_rsp_t             rsp,            // Chosen direction, one cycle later.
  input  wire logic              cfg_in_valid,   // Configuration token offered.
  input  wire token_t            cfg_in,         // Configuration token.
  output logic                   cfg_in_ready,   // Token accepted this cycle.
  output logic                   cfg_out_valid,  // Reply token offered.
  output token_t                 cfg_out,        // Reply token.
  input  wire logic              cfg_out_ready,  // Reply token taken.
  output logic      [23:0]       reply_dest,     // Endpoint to send the reply to.
  output logic      [31:0]       route_dir_low,  // Current low direction table.
  output logic      [31:0]       route_dir_high  // Current high direction table.
);

  // The configuration port takes write messages only. A read message opens with a
  // different control token, so the idle state drops it together with its bytes.
  // Register numbers are compared over all sixteen bits. Any other number is refused
  // and answered as a failure, so a mistyped address never lands in a table.
  // The endpoint seen on reply_dest is shifted in with the message bytes. It is only
  // meaningful once the reply has started, and it keeps the last message's value
  // after the reply has ended.

  typedef struct packed {
    cfg_state_t state;
    logic [3:0] cnt;
    cfg_msg_t   msg;
    logic [7:0] rsp_byte;
    logic [31:0] dir_low;
    logic [31:0] dir_high;
    route_rsp_t out;
  } state_t;

  state_t s;
  state_t next_s;

  logic [NODE_W-1:0] mismatch;
  logic [DIM_W-1:0]  dim;
  logic              any;
  logic [DIR_W-1:0]  dir_from_low;
  logic [DIR_W-1:0]  dir_from_high;
  logic [5:0]        field_lsb;
  logic [79:0]       shifted;
  logic              reg_hit;

  assign mismatch  = req.dest ^ local_id;
  assign field_lsb = {dim, 2'b00};

  // Both tables use the same field position within their own word, so the low five
  // bits of the field position pick the nibble and the top dimension bit picks the table.
  assign dir_from_low  = s.dir_low[field_lsb[4:0] +: DIR_W];
  assign dir_from_high = s.dir_high[field_lsb[4:0] +: DIR_W];

  dir_select u_dir_select
  (
    .mismatch (mismatch),
    .dim      (dim),
    .any      (any)
  );

  // The message bytes arrive most significant first and are shifted in whole,
  // so the endpoint, register number and data fall into place after nine bytes.
  assign shifted = {s.msg, cfg_in.data};
  assign reg_hit = (s.msg.regnum == REG_DIR_LOW)
                || (s.msg.regnum == REG_DIR_HIGH);

  always_comb
  begin
    next_s = s;

    // Lookup: one register stage, no back-pressure toward the source.
    next_s.out.valid     = req.valid;
    // The tables are read as they stand before the edge, so a write that lands on
    // the same edge as a lookup only affects the lookups that follow it.
    // Dimension zero to seven has the top bit of the dimension clear.
    next_s.out.local_hit = req.valid && !any;
    if (!any)
    begin
      next_s.out.dir = '0;
    end
    else if (!dim[DIM_W-1])
    begin
      next_s.out.dir = dir_from_low;
    end
    else
    begin
      next_s.out.dir = dir_from_high;
    end

    case (s.state)
      CFG_IDLE:
      begin
        // Stray data tokens and other control tokens are dropped here.
        if (cfg_in_valid && cfg_in.ctrl && (cfg_in.data == TOK_WRITE))
        begin
          next_s.state = CFG_HDR;
          next_s.cnt   = '0;
        end
      end
      CFG_HDR:
      begin
        if (cfg_in_valid)
        begin
          if (cfg_in.ctrl)
          begin
            // A message cut short is answered as a failure, nothing is written.
            next_s.rsp_byte = TOK_NACK;
            next_s.state    = CFG_RSP1;
          end
          else
          begin
            // The counter stops at the last header byte; the closing token is
            // judged in its own state, so a tenth data byte is refused there.
            next_s.msg = shifted[71:0];
            next_s.cnt = s.cnt + CNT_ONE;
            if (s.cnt == (HDR_BYTES - CNT_ONE))
            begin
              next_s.state = CFG_CLOSE;
            end
          end
        end
      end
      CFG_CLOSE:
      begin
        if (cfg_in_valid)
        begin
          next_s.state = CFG_RSP1;
          // The table is written on the same edge as the reply starts, so the
          // success token is never shown before the new value can be used.
          if (cfg_in.ctrl && (cfg_in.data == TOK_END) && reg_hit)
          begin
            next_s.rsp_byte = TOK_ACK;
            if (s.msg.regnum == REG_DIR_LOW)
            begin
              next_s.dir_low = s.msg.wdata;
            end
            else
            begin
              next_s.dir_high = s.msg.wdata;
            end
          end
          else
          begin
            next_s.rsp_byte = TOK_NACK;
          end
        end
      end
      CFG_RSP1:
      begin
        // Each reply token stands until the sink takes it; a slow sink only
        // delays the next message, since input tokens are held off meanwhile.
        if (cfg_out_ready)
        begin
          next_s.rsp_byte = TOK_END;
          next_s.state    = CFG_RSP2;
        end
      end
      CFG_RSP2:
      begin
        if (cfg_out_ready)
        begin
          next_s.state = CFG_IDLE;
        end
      end
      default:
      begin
        next_s.state = CFG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // The reply byte rests on the failure token so that an unexpected reply
      // can never look like a success. The high table has no documented reset
      // value and starts at zero like the low one.
      s          <= '0;
      s.state    <= CFG_IDLE;
      s.rsp_byte <= TOK_NACK;
      s.dir_low  <= DIR_LOW_RST;
      s.dir_high <= DIR_HIGH_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Tokens are held off while a reply is pending, so a new message waits.
  assign cfg_in_ready   = (s.state == CFG_IDLE)
                       || (s.state == CFG_HDR)
                       || (s.state == CFG_CLOSE);
  assign cfg_out_valid  = (s.state == CFG_RSP1)
                       || (s.state == CFG_RSP2);
  assign cfg_out.ctrl   = 1'b1;
  assign cfg_out.data   = s.rsp_byte;
  assign reply_dest     = s.msg.endpoint;
  assign rsp            = s.out;
  assign route_dir_low  = s.dir_low;
  assign route_dir_high = s.dir_high;

endmodule

// ===== verif/route_properties.sv
`timescale 1ns/100ps
module route_properties
  import route_pkg::*;
(
  input wire logic        clk,           // Clock.
  input wire logic        rst_n,         // Reset.
  input wire logic [15:0] local_id,      // Own id.
  input wire route_req_t  req,           // Header.
  input wire route_rsp_t  rsp,           // Answer.
  input wire logic        cfg_in_ready,  // Taken.
  input wire logic        cfg_out_valid, // Reply.
  input wire token_t      cfg_out,       // Reply.
  input wire logic        cfg_out_ready, // Taken.
  input wire logic [31:0] route_dir_low, // Table.
  input wire logic [31:0] route_dir_high // Table.
);
  logic [15:0] mm;
  logic [3:0]  d;
  logic [63:0] tbl;
  logic [3:0]  want;
  always_comb
  begin
    mm = req.dest ^ local_id;
    tbl = {route_dir_high, route_dir_low};
    d = 4'h0;
    for (int i = 0; i < 16; i++)
      if (mm[i])
        d = 4'(i);
    want = tbl[{d, 2'b0} +: 4];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_val; 1 |=> rsp.valid == $past(req.valid); endproperty
  a_val: assert property (p_val) else $error("valid");
  property p_low; req.valid && mm != 0 && mm[15:8] == 0 |=> rsp.dir == $past(want) && !rsp.local_hit; endproperty
  a_low: assert property (p_low) else $error("low dir");
  property p_high; req.valid && mm[15:8] != 0 |=> rsp.dir == $past(want); endproperty
  a_high: assert property (p_high) else $error("high dir");
  property p_top; req.valid && mm[15:7] == 9'h001 |=> rsp.dir == $past(route_dir_low[31:28]); endproperty
  a_top: assert property (p_top) else $error("dim 7");
  property p_rst; $rose(rst_n) |-> route_dir_low == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_hold; cfg_out_valid && !cfg_out_ready |=> cfg_out_valid && $stable(cfg_out); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_end; cfg_out_valid && cfg_out_ready && cfg_out.data != TOK_END |=> cfg_out_valid && cfg_out.data == TOK_END && !cfg_in_ready; endproperty
  a_end: assert property (p_end) else $error("end");
  property p_loc; req.valid && mm == 0 |=> rsp.local_hit && rsp.dir == 4'h0; endproperty
  a_loc: assert property (p_loc) else $error("local");
endmodule
bind packet_direction_lookup route_properties i_route_properties (.*);

// ===== verif/cfg_source.sv
`timescale 1ns/100ps
module cfg_source
  import route_pkg::*;
(
  input  wire logic clk,       // Clock.
  input  wire logic tok_ready, // Taken.
  output logic      tok_valid, // Offered.
  output token_t    tok,       // Token.
  output logic      rsp_ready  // Reply taken.
);
  logic stall = 1'b0;
  initial
  begin
    tok_valid = 1'b0;
    tok = '0;
    rsp_ready = 1'b1;
  end
  // A stalling sink toggles ready, so each reply must stand through refusals.
  always @(negedge clk)
    rsp_ready <= stall ? ~rsp_ready : 1'b1;
  task automatic put(input logic c, input logic [7:0] v);
    @(negedge clk);
    tok_valid = 1'b1;
    tok = {c, v};
    for (int i = 0; i < 8 && !tok_ready; i++)
      @(negedge clk);
    if (tok_ready !== 1'b1)
    begin
      packet_direction_lookup_tb.err_count++;
      $display("[ERR] tok_ready exp 1 got %b", tok_ready);
    end
    @(posedge clk);
  endtask
  task automatic idle();
    @(negedge clk);
    tok_valid = 1'b0;
    tok = ~tok;
  endtask
endmodule

// ===== verif/packet_direction_lookup_tb.sv
`timescale 1ns/100ps
module packet_direction_lookup_tb;
  import route_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] local_id = 16'ha5a5;
  route_req_t  req = '0;
  route_rsp_t  rsp;
  logic        cfg_in_valid, cfg_in_ready, cfg_out_valid, cfg_out_ready;
  token_t      cfg_in, cfg_out;
  logic [23:0] reply_dest;
  logic [31:0] route_dir_low, route_dir_high;
  int          err_count = 0;
  int          n_checks = 0;
  initial
    forever #25 clk = ~clk;
  packet_direction_lookup i_packet_direction_lookup (.*);
  cfg_source i_cfg_source (.clk(clk), .tok_ready(cfg_in_ready), .tok_valid(cfg_in_valid), .tok(cfg_in),
    .rsp_ready(cfg_out_ready));
  task automatic final_report();
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic look(input logic [15:0] dest, input logic [5:0] exp);
    @(negedge clk);
    req = {1'b1, dest};
    @(negedge clk);
    req.valid = 1'b0;
    chk("route", 32'(exp), 32'(rsp));
  endtask
  task automatic get_reply(input logic [7:0] exp);
    logic [15:0] got;
    int          n;
    got = '0;
    n = 0;
    for (int i = 0; i < 20 && n < 2; i++)
    begin
      // Ready is updated on the falling edge, so look just after it.
      #1;
      if (cfg_out_valid === 1'b1 && cfg_out_ready === 1'b1)
      begin
        chk("reply ctrl", 32'h1, 32'(cfg_out.ctrl));
        got = {got[7:0], cfg_out.data};
        n++;
      end
      @(negedge clk);
    end
    chk("reply", {16'h0, exp, TOK_END}, {16'h0, got});
    if (n < 2)
    begin
      err_count++;
      final_report();
    end
  endtask
  task automatic wr(input logic [15:0] rn, input logic [31:0] v, input logic [7:0] exp);
    logic [71:0] body;
    body = {24'h12ab34, rn, v};
    i_cfg_source.put(1'b1, TOK_WRITE);
    for (int i = 8; i >= 0; i--)
      i_cfg_source.put(1'b0, body[i*8 +: 8]);
    i_cfg_source.put(1'b1, TOK_END);
    i_cfg_source.idle();
    get_reply(exp);
    chk("endpoint", 32'h12ab34, 32'(reply_dest));
  endtask
  task automatic wr_cut();
    i_cfg_source.put(1'b1, TOK_WRITE);
    for (int i = 0; i < 3; i++)
      i_cfg_source.put(1'b0, 8'h5a);
    i_cfg_source.put(1'b1, TOK_WRITE);
    i_cfg_source.idle();
    get_reply(TOK_NACK);
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("low reset", DIR_LOW_RST, route_dir_low);
    wr(REG_DIR_LOW, 32'h76543210, TOK_ACK);
    i_cfg_source.stall = 1'b1;
    wr(REG_DIR_HIGH, 32'hfedcba98, TOK_ACK);
    i_cfg_source.stall = 1'b0;
    wr(16'h000e, 32'h0, TOK_NACK);
    chk("high", 32'hfedcba98, route_dir_high);
    wr_cut();
    chk("low kept", 32'h76543210, route_dir_low);
    chk("high kept", 32'hfedcba98, route_dir_high);
    for (int d = 0; d < 16; d++)
      look(local_id ^ 16'((32'h2 << d) - 1), {2'b10, 4'(d)});
    look(local_id, 6'h30);
    final_report();
  end
endmodule
